/* File: touch_key_regs.svh */
// Purpose: Named constants for the touch key mode and output control block
// Assumes: 50 MHz core clock
// Notes: Times are kept in their own unit; cycle counts derive from them
`ifndef TOUCH_KEY_REGS_SVH
`define TOUCH_KEY_REGS_SVH

// Clock and time base
`define CLK_NS 20
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_NS)
`define RST_PULSE_NS 640
`define RST_PULSE_CYC ((`RST_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define IRQ_PULSE_NS 1000
`define IRQ_PULSE_CYC ((`IRQ_PULSE_NS + `CLK_NS - 1) / `CLK_NS)

// Option vector bit positions
`define OPT_MODE 0
`define OPT_TWO 1
`define OPT_THREE 2
`define OPT_FOUR 3
`define OPT_FIVE 4
`define OPT_SIX 5

// Sleep and stuck-key limits in milliseconds
`define SLEEP_MS 16'h0064
`define TO_NONE_MS 16'h0000
`define TO_60S_MS 16'hEA60
`define TO_20S_MS 16'h4E20
`define TO_10S_MS 16'h2710

// Detection integrator: consecutive agreeing samples
`define DI_SAMPLES 2'h3

// Host low-power selections
`define LP_NONE 2'h0
`define LP_STANDARD 2'h1
`define LP_FREERUN 2'h2
`define LP_DEEP 2'h3

`endif

/* File: touch_key_pkg.sv */
// Purpose: Types shared by the touch key control modules
// Assumes: Constants come from touch_key_regs.svh
// Notes: One packed struct per module holds all of its state
package touch_key_pkg;

   typedef enum logic [6:0] {
      ST_CONFIG  = 7'b0000001,
      ST_BURST_A = 7'b0000010,
      ST_BURST_B = 7'b0000100,
      ST_EVAL    = 7'b0001000,
      ST_DECIDE  = 7'b0010000,
      ST_SLEEP   = 7'b0100000,
      ST_DEEP    = 7'b1000000
   } ctrl_state_e;

   typedef struct packed {
      ctrl_state_e st;
      logic [5:0] opt;
      logic [15:0] msCnt;
      logic msTick;
      logic [15:0] sleepCnt;
      logic [7:0] rstCnt;
      logic rstOe;
      logic [7:0] irqCnt;
      logic irqOe;
      logic irqHold;
      logic ackBlock;
      logic ackEn;
      logic [3:0] lockKey;
      logic [7:0] prevTouch;
      logic [7:0] prevFault;
      logic burstReq;
      logic burstSel;
      logic sampleStb;
      logic [7:0] keyOut;
      logic [7:0] keyOe;
      logic [7:0] recal;
      logic sleeping;
   } ctrl_s;

   typedef struct packed {
      logic [1:0] diCnt;
      logic touched;
      logic [15:0] onCnt;
      logic recal;
   } chan_s;

endpackage : touch_key_pkg

/* File: key_chan_if.sv */
// Purpose: Link between the controller and one key channel
// Assumes: Same clock on both sides
// Notes: Controller drives strobes and limits, channel returns its state
`timescale 1ns/10ps
interface key_chan_if;
   logic clear;
   logic sampleStb;
   logic rawTouch;
   logic msTick;
   logic [15:0] onLimit;
   logic touched;
   logic qualifying;
   logic recal;

   modport ctrl (output clear, sampleStb, rawTouch, msTick, onLimit, input touched, qualifying, recal);
   modport chan (input clear, sampleStb, rawTouch, msTick, onLimit, output touched, qualifying, recal);
endinterface : key_chan_if

/* File: key_channel.sv */
// Purpose: One key's detection integrator and stuck-key timeout
// Assumes: sampleStb once per acquisition cycle, msTick once per millisecond
// Notes: A timeout clears only this channel
`timescale 1ns/10ps
module key_channel
   import touch_key_pkg::*;
(
   input wire logic clk,        // Core clock
   input wire logic nrst,       // Synchronous reset, active low
   key_chan_if.chan ch          // Controller link
);
`include "touch_key_regs.svh"

   chan_s s_r;
   chan_s s_nxt;

   // Integrate samples, then time the touch
   always_comb begin
      s_nxt = s_r;
      s_nxt.recal = 1'b0;
      if (ch.clear) begin
         s_nxt = '0;
      end else begin
         if (ch.sampleStb) begin
            if (ch.rawTouch != s_r.touched) begin
               if (s_r.diCnt == (`DI_SAMPLES - 2'h1)) begin
                  s_nxt.touched = ch.rawTouch;
                  s_nxt.diCnt = 2'h0;
                  s_nxt.onCnt = 16'h0000;
               end else begin
                  s_nxt.diCnt = s_r.diCnt + 2'h1;
               end
            end else begin
               s_nxt.diCnt = 2'h0;
            end
         end
         if (ch.msTick && s_nxt.touched && (ch.onLimit != `TO_NONE_MS)) begin
            if (s_r.onCnt == (ch.onLimit - 16'h0001)) begin
               s_nxt.touched = 1'b0;
               s_nxt.recal = 1'b1;
               s_nxt.onCnt = 16'h0000;
            end else begin
               s_nxt.onCnt = s_r.onCnt + 16'h0001;
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ch.touched = s_r.touched;
   // Counts the sample taken this cycle, so the first differing sample already holds off sleep
   assign ch.qualifying = (s_nxt.diCnt != 2'h0);
   assign ch.recal = s_r.recal;

endmodule : key_channel

/* File: touch_key_ctrl.sv */
// Purpose: Option decode, burst sequencing, sleep scheduling and key outputs
// Assumes: Analogue front end and I2C engine sit outside and talk by strobes
// Notes: The two-way reset pin is split into in, out and enable; open-drain outputs into value and enable
`timescale 1ns/10ps
// Ahead of the header: the parameter default needs the tick count
`include "touch_key_regs.svh"
module touch_key_ctrl
   import touch_key_pkg::*;
#(
   parameter int MS_CYCLES = `MS_CYCLES    // Clock cycles per millisecond tick
)
(
   input wire logic clk,                // Core clock, 50 MHz
   input wire logic nrst,               // Synchronous reset, active low
   input wire logic modeSelectOption,   // Mode option strap
   input wire logic optionInputTwo,     // Suppression or address bit 0
   input wire logic optionInputThree,   // Low power or address bit 1
   input wire logic optionInputFour,    // Timeout high or address bit 2
   input wire logic optionInputFive,    // Timeout low
   input wire logic optionInputSix,     // Output mode
   input wire logic resetPinIn,         // Reset pin level
   output logic resetPinOut,            // Reset pin drive value
   output logic resetPinOe,             // Reset pin drive enable
   input wire logic hostResetReq,       // Self-reset request pulse
   input wire logic [7:0] rawKeys,      // Per-key detection from front end
   input wire logic [7:0] keyImpl,      // Key implemented
   input wire logic [7:0] keyFault,     // Key faulty
   input wire logic [7:0] keyEnable,    // Host key enables
   input wire logic burstDone,          // Front end finished a burst
   output logic burstReq,               // Start burst pulse
   output logic burstSel,               // 0 keys 1-4, 1 keys 5-8
   input wire logic i2cFrameStart,      // Start of any frame
   input wire logic i2cFrameEnd,        // End of frame
   input wire logic i2cCmdDone,         // Host command received
   input wire logic i2cInCmd,           // Between write and read frame
   input wire logic [1:0] hostLpMode,   // Host low-power selection
   input wire logic [7:0] hostSleepMs,  // Host sleep length
   output logic i2cAckEn,               // I2C engine may acknowledge
   output logic [2:0] slaveAddrBits,    // Address bits from options
   output logic hostSerial,             // Host-serial mode active
   output logic irqOut,                 // Interrupt drive value
   output logic irqOe,                  // Interrupt drive enable
   output logic [5:0] keyOut,           // Push-pull key outputs
   output logic [5:0] keyOutOe,         // Their enables
   output logic keyOutputSeven,         // Open-drain output seven value
   output logic keyOutputSevenOe,       // Its enable
   output logic keyOutputEight,         // Open-drain output eight value
   output logic keyOutputEightOe,       // Its enable
   output logic [7:0] recalKeys,        // Recalibrate request per key
   output logic sleeping                // Sleep or deep sleep
);

   ctrl_s s_r;
   ctrl_s s_nxt;
   key_chan_if chIf[8] ();
   logic [7:0] tch;
   logic [7:0] qual;
   logic [7:0] chRecal;
   logic [7:0] eff;
   logic [7:0] finalKeys;
   logic [3:0] newLock;
   logic [15:0] onLimit;
   logic [15:0] sleepLen;
   logic isHost;
   logic suppress;
   logic lpOn;
   logic skipSleep;
   logic irqEv;
   logic [3:0] keyNum;

   // One channel per key, all sharing the strobes
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gChan
         assign chIf[g].clear = (s_r.st == ST_CONFIG);
         assign chIf[g].sampleStb = s_r.sampleStb;
         assign chIf[g].rawTouch = rawKeys[g];
         assign chIf[g].msTick = s_r.msTick;
         assign chIf[g].onLimit = onLimit;
         assign tch[g] = chIf[g].touched;
         assign qual[g] = chIf[g].qualifying;
         assign chRecal[g] = chIf[g].recal;
         key_channel uChan (
            .clk (clk),
            .nrst (nrst),
            .ch (chIf[g])
         );
      end
   endgenerate

   // latched options pick mode and meaning
   assign isHost = !s_r.opt[`OPT_MODE];
   assign suppress = !isHost && (s_r.opt[`OPT_SIX] || s_r.opt[`OPT_TWO]);
   assign lpOn = isHost ? ((hostLpMode == `LP_STANDARD) || (hostLpMode == `LP_FREERUN)) : s_r.opt[`OPT_THREE];
   assign sleepLen = isHost ? {8'h00, hostSleepMs} : `SLEEP_MS;

   always_comb begin
      onLimit = `TO_NONE_MS;
      if (!isHost) begin
         unique case ({s_r.opt[`OPT_FOUR], s_r.opt[`OPT_FIVE]})
            2'b00: onLimit = `TO_NONE_MS;
            2'b01: onLimit = `TO_60S_MS;
            2'b10: onLimit = `TO_20S_MS;
            2'b11: onLimit = `TO_10S_MS;
         endcase
      end
   end

   // Sleep is cancelled by activity so a touch already qualifying is not slowed by the sleep window
   always_comb begin
      skipSleep = 1'b0;
      if (|qual) skipSleep = 1'b1;
      if (isHost && (hostLpMode == `LP_FREERUN) && (|eff)) skipSleep = 1'b1;
      if (isHost && s_r.irqHold) skipSleep = 1'b1;
      if (isHost && i2cInCmd) skipSleep = 1'b1;
      if (sleepLen == 16'h0000) skipSleep = 1'b1;
   end

   always_comb begin
      eff = tch & keyImpl & ~keyFault;
      newLock = s_r.lockKey;
      if ((newLock != 4'h0) && !eff[3'(newLock - 4'h1)]) newLock = 4'h0;
      if (newLock == 4'h0) begin
         for (int i = 7; i >= 0; i--) begin
            if (eff[i]) newLock = 4'(i + 1);
         end
      end
      finalKeys = eff;
      if (suppress) begin
         for (int i = 0; i < 8; i++) begin
            finalKeys[i] = (newLock == 4'(i + 1));
         end
      end
   end

   // enabled key change, fault or recalibration
   assign irqEv = isHost && (|(((tch ^ s_r.prevTouch) | (keyFault ^ s_r.prevFault) | chRecal) & keyEnable));
   assign keyNum = newLock;

   // Main next-state logic
   always_comb begin
      s_nxt = s_r;
      s_nxt.burstReq = 1'b0;
      s_nxt.sampleStb = 1'b0;
      s_nxt.msTick = 1'b0;
      s_nxt.recal = chRecal;
      // Millisecond divider
      if (s_r.msCnt == 16'(MS_CYCLES - 1)) begin
         s_nxt.msCnt = 16'h0000;
         s_nxt.msTick = 1'b1;
      end else begin
         s_nxt.msCnt = s_r.msCnt + 16'h0001;
      end
      if (s_r.rstCnt != 8'h00) begin
         s_nxt.rstCnt = s_r.rstCnt - 8'h01;
      end else if (hostResetReq) begin
         s_nxt.rstCnt = 8'(`RST_PULSE_CYC);
      end
      s_nxt.rstOe = (s_nxt.rstCnt != 8'h00);
      // Interrupt pulse and hold; a new event wins over the host clear
      if (s_r.irqCnt != 8'h00) s_nxt.irqCnt = s_r.irqCnt - 8'h01;
      if (i2cCmdDone) s_nxt.irqHold = 1'b0;
      if (irqEv && (s_r.st != ST_CONFIG)) begin
         s_nxt.irqCnt = 8'(`IRQ_PULSE_CYC);
         s_nxt.irqHold = 1'b1;
      end
      s_nxt.irqOe = (s_nxt.irqCnt != 8'h00);
      s_nxt.prevTouch = tch;
      s_nxt.prevFault = keyFault;
      if (i2cFrameEnd) s_nxt.ackBlock = 1'b0;
      unique case (s_r.st)
         ST_CONFIG: begin
            s_nxt.opt = {optionInputSix, optionInputFive, optionInputFour,
                         optionInputThree, optionInputTwo, modeSelectOption};
            s_nxt.st = ST_BURST_A;
            s_nxt.burstReq = 1'b1;
            s_nxt.burstSel = 1'b0;
         end
         ST_BURST_A: begin
            if (burstDone) begin
               if (|keyImpl[7:4]) begin
                  s_nxt.st = ST_BURST_B;
                  s_nxt.burstReq = 1'b1;
                  s_nxt.burstSel = 1'b1;
               end else begin
                  s_nxt.st = ST_EVAL;
               end
            end
         end
         ST_BURST_B: begin
            if (burstDone) s_nxt.st = ST_EVAL;
         end
         ST_EVAL: begin
            s_nxt.sampleStb = 1'b1;
            s_nxt.st = ST_DECIDE;
         end
         ST_DECIDE: begin
            if (isHost && (hostLpMode == `LP_DEEP) && !s_r.irqHold && !i2cInCmd) begin
               s_nxt.st = ST_DEEP;
            end else if (lpOn && !skipSleep) begin
               s_nxt.st = ST_SLEEP;
               s_nxt.sleepCnt = sleepLen;
            end else begin
               s_nxt.st = ST_BURST_A;
               s_nxt.burstReq = 1'b1;
               s_nxt.burstSel = 1'b0;
            end
         end
         ST_SLEEP: begin
            if (i2cFrameStart) begin
               s_nxt.ackBlock = 1'b1;
               s_nxt.st = ST_BURST_A;
               s_nxt.burstReq = 1'b1;
               s_nxt.burstSel = 1'b0;
            end else if (s_r.msTick) begin
               if (s_r.sleepCnt <= 16'h0001) begin
                  s_nxt.st = ST_BURST_A;
                  s_nxt.burstReq = 1'b1;
                  s_nxt.burstSel = 1'b0;
               end else begin
                  s_nxt.sleepCnt = s_r.sleepCnt - 16'h0001;
               end
            end
         end
         ST_DEEP: begin
            if (i2cFrameStart) begin
               s_nxt.ackBlock = 1'b1;
               s_nxt.st = ST_BURST_A;
               s_nxt.burstReq = 1'b1;
               s_nxt.burstSel = 1'b0;
            end
         end
      endcase
      s_nxt.lockKey = (s_r.st == ST_CONFIG) ? 4'h0 : newLock;
      s_nxt.sleeping = (s_nxt.st == ST_SLEEP) || (s_nxt.st == ST_DEEP);
      s_nxt.ackEn = isHost && !s_nxt.ackBlock && !s_nxt.sleeping && (s_r.st != ST_CONFIG);
      if (s_r.opt[`OPT_SIX]) begin
         s_nxt.keyOut = {4'h0, keyNum};
      end else begin
         s_nxt.keyOut = finalKeys;
      end
      // push-pull low six, open-drain seven and eight
      if (isHost || (s_r.st == ST_CONFIG)) begin
         s_nxt.keyOe = 8'h00;
      end else begin
         s_nxt.keyOe = {~s_nxt.keyOut[7:6], 6'h3F};
      end
      if (!resetPinIn) begin
         s_nxt = '0;
         s_nxt.st = ST_CONFIG;
         s_nxt.msCnt = s_r.msCnt;
         s_nxt.rstCnt = (s_r.rstCnt != 8'h00) ? s_r.rstCnt - 8'h01 : 8'h00;
         s_nxt.rstOe = (s_nxt.rstCnt != 8'h00);
      end
   end

   // State register; reset also leaves all key outputs undriven
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_r <= '0;
         s_r.st <= ST_CONFIG;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Open-drain and reset pins only ever pull low
   assign resetPinOut = 1'b0;
   assign resetPinOe = s_r.rstOe;
   assign irqOut = 1'b0;
   assign irqOe = s_r.irqOe;
   assign burstReq = s_r.burstReq;
   assign burstSel = s_r.burstSel;
   assign i2cAckEn = s_r.ackEn;
   assign slaveAddrBits = s_r.opt[`OPT_FOUR:`OPT_TWO];
   assign hostSerial = !s_r.opt[`OPT_MODE];
   assign keyOut = s_r.keyOut[5:0];
   assign keyOutOe = s_r.keyOe[5:0];
   assign keyOutputSeven = 1'b0;
   assign keyOutputSevenOe = s_r.keyOe[6];
   assign keyOutputEight = 1'b0;
   assign keyOutputEightOe = s_r.keyOe[7];
   assign recalKeys = s_r.recal;
   assign sleeping = s_r.sleeping;

endmodule : touch_key_ctrl

/* File: touch_key_ctrl_asserts.sv */
// Purpose: Port-level checks for touch_key_ctrl
// Assumes: Inputs change just after the rising edge
// Notes: Attached by bind and sees top-level ports only
`timescale 1ns/10ps
module touch_key_ctrl_asserts (
   input wire logic clk,              // Core clock
   input wire logic nrst,             // Reset, active low
   input wire logic resetPinIn,       // Reset pin level
   input wire logic resetPinOut,      // Reset drive value
   input wire logic resetPinOe,       // Reset drive enable
   input wire logic hostResetReq,     // Self-reset request
   input wire logic [7:0] keyImpl,    // Key fitted
   input wire logic burstReq,         // Burst start
   input wire logic burstSel,         // Burst group
   input wire logic i2cFrameStart,    // Frame start
   input wire logic i2cAckEn,         // Ack permission
   input wire logic hostSerial,       // Host mode
   input wire logic irqOut,           // Interrupt value
   input wire logic irqOe,            // Interrupt enable
   input wire logic [5:0] keyOutOe,   // Push-pull enables
   input wire logic keyOutputSeven,   // Open-drain seven
   input wire logic keyOutputSevenOe, // Its enable
   input wire logic keyOutputEight,   // Open-drain eight
   input wire logic keyOutputEightOe, // Its enable
   input wire logic [7:0] recalKeys,  // Recalibrate pulses
   input wire logic sleeping          // Sleep state
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // Reset must not be masked here, it is the cause being checked
   a_rst_float: assert property (disable iff (1'b0) !nrst |=> keyOutOe == 6'h00 && !keyOutputSevenOe
      && !keyOutputEightOe) else $error("key outputs driven in reset");
   a_first_burst: assert property (!$past(nrst) && resetPinIn |=> burstReq && !burstSel)
      else $error("first burst after reset is not group A");
   // The group B decision was taken on the fit seen one edge earlier
   a_b_needs_keys: assert property (burstReq && burstSel |-> $past(keyImpl[7:4]) != 4'h0)
      else $error("group B burst with no keys fitted");
   // Open-drain lines may only ever pull low
   a_od_low_only: assert property (!keyOutputSeven && !keyOutputEight && !resetPinOut && !irqOut)
      else $error("open-drain line driven high");
   a_self_reset: assert property (hostResetReq && !resetPinOe |=> resetPinOe [*8])
      else $error("self reset does not pull reset pin");
   a_irq_host_only: assert property (irqOe |-> hostSerial)
      else $error("interrupt driven in stand-alone mode");
   a_irq_pulse: assert property ($rose(irqOe) |-> irqOe [*8])
      else $error("interrupt pulse too short");
   a_sleep_no_ack: assert property (sleeping |-> !i2cAckEn)
      else $error("ack allowed while asleep");
   a_wake_no_ack: assert property (sleeping && i2cFrameStart |=> !i2cAckEn [*2])
      else $error("waking frame acknowledged");
   a_recal_once: assert property (|recalKeys |=> (recalKeys & $past(recalKeys)) == 8'h00)
      else $error("recalibration pulse longer than one cycle");
endmodule : touch_key_ctrl_asserts

bind touch_key_ctrl touch_key_ctrl_asserts chk (.clk, .nrst, .resetPinIn, .resetPinOut, .resetPinOe,
   .hostResetReq, .keyImpl, .burstReq, .burstSel, .i2cFrameStart, .i2cAckEn, .hostSerial, .irqOut, .irqOe,
   .keyOutOe, .keyOutputSeven, .keyOutputSevenOe, .keyOutputEight, .keyOutputEightOe, .recalKeys, .sleeping);

/* File: front_end_model.sv */
// Purpose: Behavioural sensing front end answering burst requests
// Assumes: burstSel is held for the whole burst
// Notes: Raw results change only when the burst of their group ends
`timescale 1ns/10ps
module front_end_model (
   input wire logic clk,             // Core clock
   input wire logic nrst,            // Reset, active low
   input wire logic burstReq,        // Burst start
   input wire logic burstSel,        // Burst group
   input wire logic [7:0] touch,     // Finger presence per key
   input wire logic [4:0] lat,       // Cycles to answer, 1 is prompt
   output logic burstDone,           // Burst finished
   output logic [7:0] rawKeys,       // Detection per key
   output logic [7:0] burstBCount    // Group B bursts seen
);
   logic busy_r;
   logic [4:0] wait_r;

   // One burst at a time; a slow latency stretches every acquisition
   always_ff @(posedge clk) begin
      burstDone <= 1'b0;
      if (!nrst) begin
         busy_r <= 1'b0;
         rawKeys <= 8'h00;
         burstBCount <= 8'h00;
      end else if (burstReq) begin
         busy_r <= 1'b1;
         wait_r <= lat;
         burstBCount <= burstBCount + {7'h00, burstSel};
      end else if (busy_r && wait_r <= 5'h01) begin
         busy_r <= 1'b0;
         burstDone <= 1'b1;
         if (burstSel) begin
            rawKeys[7:4] <= touch[7:4];
         end else begin
            rawKeys[3:0] <= touch[3:0];
         end
      end else begin
         wait_r <= wait_r - 5'h01;
      end
   end
endmodule : front_end_model

/* File: test_touch_key_ctrl.sv */
// Purpose: Self-checking bench for touch_key_ctrl
// Assumes: Millisecond tick shortened to 4 cycles
// Notes: Reset pin resolved here with its pull-up
`timescale 1ns/10ps
module test_touch_key_ctrl;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [5:0] opt = 6'h01;
   logic pinDrv = 1'b1;
   logic [3:0] stb = 4'h0;
   logic [7:0] touch = 8'h00;
   logic [7:0] keyImpl = 8'hFF;
   logic [4:0] lat = 5'h01;
   logic [1:0] hostLpMode = 2'h0;
   logic inCmd = 1'b0;
   int bad_count = 0;
   int num_checks = 0;
   logic resetPinOut, resetPinOe, burstReq, burstSel, burstDone, i2cAckEn, hostSerial, irqOut, irqOe, sleeping;
   logic keyOutputSeven, keyOutputSevenOe, keyOutputEight, keyOutputEightOe;
   logic [2:0] slaveAddrBits;
   logic [5:0] keyOut, keyOutOe;
   logic [7:0] rawKeys, recalKeys, burstBCount;
   wire resetPinIn = pinDrv & ~resetPinOe;
   wire [2:0] mon = {sleeping, irqOe, resetPinOe};
   wire [7:0] keysSeen = {keyOutputEightOe, keyOutputSevenOe, keyOut};

   always #10 clk = ~clk;

   // Design and front end
   touch_key_ctrl #(.MS_CYCLES(4)) dut (.clk, .nrst, .modeSelectOption(opt[0]), .optionInputTwo(opt[1]),
      .optionInputThree(opt[2]), .optionInputFour(opt[3]), .optionInputFive(opt[4]), .optionInputSix(opt[5]),
      .resetPinIn, .resetPinOut, .resetPinOe, .hostResetReq(stb[3]), .rawKeys, .keyImpl, .keyFault(8'h00),
      .keyEnable(8'hFF), .burstDone, .burstReq, .burstSel, .i2cFrameStart(stb[0]), .i2cFrameEnd(stb[1]),
      .i2cCmdDone(stb[2]), .i2cInCmd(inCmd), .hostLpMode, .hostSleepMs(8'h00), .i2cAckEn, .slaveAddrBits,
      .hostSerial, .irqOut, .irqOe, .keyOut, .keyOutOe, .keyOutputSeven, .keyOutputSevenOe, .keyOutputEight,
      .keyOutputEightOe, .recalKeys, .sleeping);
   front_end_model fe (.clk, .nrst, .burstReq, .burstSel, .touch, .lat, .burstDone, .rawKeys, .burstBCount);

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // One-cycle strobe {reset request, command done, frame end, frame start}
   task automatic strobe(input logic [3:0] s);
      @(posedge clk);
      stb <= s;
      @(posedge clk);
      stb <= 4'h0;
   endtask : strobe

   // Bounded wait; running out ends the run
   task automatic rise(input int b, input int lim);
      int i;
      for (i = 0; i < lim && mon[b] !== 1'b1; i++) @(negedge clk);
      chk("rise", 1'b1, mon[b]);
      if (i == lim) tally_and_finish();
   endtask : rise

   task automatic pulse_len(input int b, output int n);
      rise(b, 2000);
      for (n = 0; n < 2000 && mon[b] === 1'b1; n++) @(negedge clk);
   endtask : pulse_len

   task automatic wait_keys(input logic [7:0] e);
      int i;
      for (i = 0; i < 600 && keysSeen !== e; i++) @(negedge clk);
      chk("keys", e, keysSeen);
      if (i == 600) tally_and_finish();
   endtask : wait_keys

   task automatic set_touch(input logic [7:0] t, input logic [7:0] e);
      @(posedge clk);
      touch <= t;
      wait_keys(e);
   endtask : set_touch

   task automatic awake(input int n);
      logic [15:0] c;
      c = 16'h0000;
      repeat (n) @(negedge clk) c += sleeping;
      chk("no sleep", 0, c);
   endtask : awake

   // Pin reset re-reads the straps
   task automatic reconfig(input logic [5:0] o);
      @(posedge clk);
      opt <= o;
      pinDrv <= 1'b0;
      tick(3);
      pinDrv <= 1'b1;
      tick(3);
   endtask : reconfig

   task automatic t_reset;
      tick(3);
      @(negedge clk);
      chk("reset oe", 8'h00, {keyOutputEightOe, keyOutputSevenOe, keyOutOe});
      tick(3);
      nrst <= 1'b1;
   endtask : t_reset

   task automatic t_individual;
      set_touch(8'hA5, 8'h65);
      chk("drive", 7'h3F, {hostSerial, keyOutOe});
      set_touch(8'h5A, 8'h9A);
      awake(300);
      // Straps moved after configuration must change nothing
      @(posedge clk);
      opt <= 6'h23;
      set_touch(8'h04, 8'hC4);
      reconfig(6'h21);
      wait_keys(8'hC3);
   endtask : t_individual

   task automatic t_binary;
      for (int k = 1; k <= 8; k++) begin
         set_touch(8'h00, 8'hC0);
         set_touch(8'h01 << (k - 1), 8'hC0 | 8'(k));
      end
      set_touch(8'h00, 8'hC0);
      set_touch(8'h0C, 8'hC3);
   endtask : t_binary

   task automatic t_locking;
      logic [7:0] bc;
      @(posedge clk);
      keyImpl <= 8'h0F;
      lat <= 5'h14;
      reconfig(6'h03);
      bc = burstBCount;
      set_touch(8'h06, 8'hC2);
      set_touch(8'h07, 8'hC2);
      tick(300);
      wait_keys(8'hC2);
      set_touch(8'h05, 8'hC1);
      chk("group b", bc, burstBCount);
      @(posedge clk);
      keyImpl <= 8'hFF;
      lat <= 5'h01;
   endtask : t_locking

   task automatic t_sleep;
      int n;
      reconfig(6'h05);
      set_touch(8'h00, 8'hC0);
      pulse_len(2, n);
      chk("sleep length", 1'b1, n >= 397 && n <= 401);
      rise(2, 2000);
      @(posedge clk);
      touch <= 8'h01;
      pulse_len(2, n);
      rise(2, 2000);
      // Output follows the channel one edge later
      @(negedge clk);
      chk("qualified", 1'b1, keyOut[0]);
   endtask : t_sleep

   task automatic t_selfreset;
      int n;
      strobe(4'h8);
      pulse_len(0, n);
      chk("reset pulse", 32, n);
   endtask : t_selfreset

   task automatic t_timeout;
      int n;
      reconfig(6'h19);
      set_touch(8'h01, 8'hC1);
      @(posedge clk);
      touch <= 8'h03;
      for (n = 0; n < 41000 && recalKeys === 8'h00; n++) @(negedge clk);
      chk("recal", 8'h01, recalKeys);
      chk("other key", 1'b1, keyOut[1]);
      chk("timeout", 1'b1, n >= 39900 && n <= 40100);
   endtask : t_timeout

   task automatic t_host;
      int n;
      reconfig(6'h0A);
      chk("address", 4'hD, {hostSerial, slaveAddrBits});
      chk("host oe", 8'h00, {keyOutputEightOe, keyOutputSevenOe, keyOutOe});
      pulse_len(1, n);
      chk("irq pulse", 50, n);
      @(posedge clk);
      hostLpMode <= 2'h3;
      awake(300);
      // Command still open: clearing the interrupt alone must not let it sleep
      @(posedge clk);
      inCmd <= 1'b1;
      strobe(4'h4);
      awake(100);
      @(posedge clk);
      inCmd <= 1'b0;
      rise(2, 200);
      tick(400);
      chk("deep", 1'b1, sleeping);
      hostLpMode <= 2'h0;
      strobe(4'h1);
      tick(2);
      chk("woken", 2'h0, {sleeping, i2cAckEn});
      strobe(4'h2);
      tick(3);
      chk("ack", 1'b1, i2cAckEn);
   endtask : t_host

   // Main sequence
   initial begin
      t_reset();
      t_individual();
      t_binary();
      t_locking();
      t_sleep();
      t_selfreset();
      t_timeout();
      t_host();
      tally_and_finish();
   end
endmodule : test_touch_key_ctrl
